/* File: dv/fsr_host_model.sv */
// bus controller model reading the sensor over the open-drain link
`default_nettype none
module fsr_host_model (
	// bus lines
	output logic      scl,
	output wire logic sda,
	// device pin
	input  wire logic sda_oe,
	input  wire logic sda_out
);
	timeunit 1ns;
	timeprecision 10ps;
	// ----------------------------------------
	// bus primitives
	// ----------------------------------------
	logic low = 1'b0;
	// released wire goes to the pull-up level
	assign sda = (low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
	// clock stands high outside frames
	initial scl = 1'b1;
	// data moves 1 ns after the fall, so no false start is seen
	task automatic slot(input logic b, output logic s);
		#1 low = !b;
		#6.5 scl = 1'b1;
		s = sda;
		#7.5 scl = 1'b0;
	endtask
	task automatic start();
		scl = 1'b0;
		#1 low = 1'b0;
		#6.5 scl = 1'b1;
		#3.75 low = 1'b1;
		#3.75 scl = 1'b0;
	endtask
	task automatic stop();
		#1 low = 1'b1;
		#6.5 scl = 1'b1;
		#3.75 low = 1'b0;
		#3.75;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			slot(d[i], s);
		end
		slot(1'b1, nak);
	endtask
	task automatic rbyte(output logic [7:0] d, input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			slot(1'b1, d[i]);
		end
		slot(!ack, s);
	endtask
endmodule
`default_nettype wire

/* File: dv/fsr_readout_asserts.sv */
// checker for the measurement words and the data pin
`default_nettype none
module fsr_readout_checker (
	// clocks and reset
	input wire logic               CLOCK,
	input wire logic               SCL_CLK,
	input wire logic               RESET,
	// watched ports
	input wire logic               SDA_OUT,
	input wire logic               SDA_OE,
	input wire logic signed [23:0] FLOW_TENTH_UL,
	input wire logic signed [23:0] TEMP_MILLI_C,
	input wire logic signed [15:0] FLOW_WORD,
	input wire logic signed [15:0] TEMP_WORD
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	// two clock domains here, so every property names its own clock
	a_flow_clamp_high: assert property (@(posedge CLOCK) disable iff (RESET)
		FLOW_TENTH_UL > 32500 |=> FLOW_WORD == 32500) else $error("flow word not clamped high");
	a_flow_clamp_low: assert property (@(posedge CLOCK) disable iff (RESET)
		FLOW_TENTH_UL < -32500 |=> FLOW_WORD == -32500) else $error("flow word not clamped low");
	a_flow_range: assert property (@(posedge CLOCK) disable iff (RESET)
		FLOW_WORD >= -32500 && FLOW_WORD <= 32500) else $error("flow word out of range");
	a_flow_scaled: assert property (@(posedge CLOCK) disable iff (RESET)
		(FLOW_TENTH_UL >= -32500 && FLOW_TENTH_UL <= 32500)
		|=> FLOW_WORD == $past(FLOW_TENTH_UL)) else $error("flow word wrong");
	a_temp_scaled: assert property (@(posedge CLOCK) disable iff (RESET)
		(TEMP_MILLI_C > -163840 && TEMP_MILLI_C < 163840)
		|=> TEMP_WORD == $past(TEMP_MILLI_C) / 5) else $error("temperature word wrong");
	a_temp_sat_high: assert property (@(posedge CLOCK) disable iff (RESET)
		TEMP_MILLI_C > 163839 |=> TEMP_WORD == 32767)
		else $error("temperature not saturated high");
	a_temp_sat_low: assert property (@(posedge CLOCK) disable iff (RESET)
		TEMP_MILLI_C < -163840 |=> TEMP_WORD == -32768)
		else $error("temperature not saturated low");
	// open drain: a high level would fight the host pulling the line low
	a_open_drain: assert property (@(posedge CLOCK) disable iff (RESET)
		SDA_OUT == 1'b0) else $error("data pin driven high");
	// the host's ack slot follows every reply byte, so no pull outlasts eight bits except the address ack joined to a zero first byte
	a_ack_slot_free: assert property (@(negedge SCL_CLK) disable iff (RESET)
		SDA_OE [*8] |=> !SDA_OE) else $error("data line not released for the ack slot");
endmodule
bind fsr_readout fsr_readout_checker i_chk (.CLOCK(CLOCK), .SCL_CLK(SCL_CLK), .RESET(RESET),
	.SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .FLOW_TENTH_UL(FLOW_TENTH_UL),
	.TEMP_MILLI_C(TEMP_MILLI_C), .FLOW_WORD(FLOW_WORD), .TEMP_WORD(TEMP_WORD));
`default_nettype wire

/* File: dv/fsr_readout_tb_top.sv */
// self-checking bench for the identification readout
`default_nettype none
module fsr_readout_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// environment
	// ----------------------------------------
	// identity values are arbitrary; the zero byte makes the longest pull on the data line
	localparam logic [95:0] ID = {24'h3c5a96, 8'h02, 64'hf00d003456789abc};
	logic               clock = 1'b0;
	logic               reset = 1'b1;
	logic signed [23:0] flow_in = 24'h0;
	logic signed [23:0] temp_in = 24'h0;
	logic signed [15:0] flow_word;
	logic signed [15:0] temp_word;
	logic               sda_out;
	logic               sda_oe;
	logic               armed;
	wire                scl;
	wire                sda;
	int                 n_fail = 0;
	int                 checked = 0;
	always #5 clock = ~clock;
	fsr_readout #(.PRODUCT_CODE(ID[95:72]), .REVISION(ID[71:64])) i_dut (.CLOCK(clock),
		.RESET(reset), .SCL_CLK(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.SERIAL_NUMBER(ID[63:0]), .FLOW_TENTH_UL(flow_in), .TEMP_MILLI_C(temp_in),
		.FLOW_WORD(flow_word), .TEMP_WORD(temp_word), .ID_ARMED(armed));
	fsr_host_model i_host (.scl(scl), .sda(sda), .sda_oe(sda_oe), .sda_out(sda_out));
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	// independent of the design's own checksum code
	function automatic logic [7:0] crc_of(input logic [15:0] d);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
		end
		return c;
	endfunction
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic cmd(input logic [15:0] c);
		logic [2:0] nak;
		i_host.start();
		i_host.wbyte(8'h10, nak[2]);
		i_host.wbyte(c[15:8], nak[1]);
		i_host.wbyte(c[7:0], nak[0]);
		i_host.stop();
		chk("write acks", 16'(nak), 16'h0);
	endtask
	task automatic rd(input int n);
		logic       nak;
		logic [7:0] b;
		logic [7:0] e;
		logic [15:0] w;
		i_host.start();
		i_host.wbyte(8'h11, nak);
		chk("read header ack", 16'(nak), 16'h0);
		for (int k = 0; k < n; k++) begin
			w = ID[95 - 16 * (k / 3) -: 16];
			e = (k % 3 == 0) ? w[15:8] : (k % 3 == 1) ? w[7:0] : crc_of(w);
			i_host.rbyte(b, k < n - 1);
			chk("reply byte", 16'(b), 16'(e));
		end
		if (n < 18) begin
			i_host.rbyte(b, 1'b0);
			chk("released line", 16'(b), 16'h00ff);
		end
		i_host.stop();
		chk("data pin idle", 16'(sda_oe), 16'h0);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_meas();
		logic [23:0] fi [5] = '{24'h009c40, 24'hff63c0, 24'h0004d2, 24'h007ef4, 24'hff810b};
		logic [15:0] fe [5] = '{16'h7ef4, 16'h810c, 16'h04d2, 16'h7ef4, 16'h810c};
		logic [23:0] ti [5] = '{24'h0061a8, 24'hfffff9, 24'h030d40, 24'hfcf2c0, 24'hfd8000};
		logic [15:0] te [5] = '{16'h1388, 16'hffff, 16'h7fff, 16'h8000, 16'h8000};
		for (int k = 0; k < 5; k++) begin
			@(negedge clock);
			flow_in = fi[k];
			temp_in = ti[k];
			@(negedge clock);
			chk("flow word", flow_word, fe[k]);
			chk("temp word", temp_word, te[k]);
		end
	endtask
	task automatic t_read_id();
		chk("crc example", 16'(crc_of(16'hbeef)), 16'h0092);
		// no measurement runs here, so both commands are taken
		cmd(16'h367c);
		cmd(16'he102);
		chk("armed", 16'(armed), 16'h1);
		rd(18);
	endtask
	task automatic t_abort();
		rd(2);
		chk("armed kept", 16'(armed), 16'h1);
	endtask
	task automatic t_refuse();
		logic nak;
		cmd(16'h3608);
		chk("armed cleared", 16'(armed), 16'h0);
		for (int i = 0; i < 2; i++) begin
			i_host.start();
			i_host.wbyte(i ? 8'h20 : 8'h11, nak);
			i_host.stop();
			chk("header refused", 16'(nak), 16'h1);
		end
	endtask
	initial begin
		repeat (12) @(posedge clock);
		@(negedge clock);
		reset = 1'b0;
		t_meas();
		t_read_id();
		t_abort();
		t_refuse();
		close_out();
	end
	// hang guard
	initial begin
		#300000;
		n_fail++;
		close_out();
	end
endmodule
`default_nettype wire

/* File: shared/fsr_pkg.sv */
// constants, types and checksum function for the flow sensor id readout
`default_nettype none
package fsr_pkg;

	// ----------------------------------------
	// command words
	// ----------------------------------------
	localparam logic [15:0] CMD_ID_FIRST  = 16'h367c;
	localparam logic [15:0] CMD_ID_SECOND = 16'he102;

	// ----------------------------------------
	// checksum
	// ----------------------------------------
	localparam logic [7:0] CRC_POLY   = 8'h31;
	localparam logic [7:0] CRC_INIT   = 8'hff;
	localparam logic [7:0] CRC_XOROUT = 8'h00;

	// ----------------------------------------
	// reply layout
	// ----------------------------------------
	localparam int          REPLY_WORDS    = 6;
	localparam int          ID_BITS        = 16 * REPLY_WORDS;
	localparam logic [4:0]  REPLY_BYTES    = 5'h12;
	localparam logic [1:0]  POS_MSB        = 2'h0;
	localparam logic [1:0]  POS_LSB        = 2'h1;
	localparam logic [1:0]  POS_CRC        = 2'h2;
	localparam logic [2:0]  LAST_BIT       = 3'h7;
	localparam logic [1:0]  SETTLE_LAST    = 2'h3;

	// ----------------------------------------
	// measurement encoding
	// ----------------------------------------
	localparam int          FLOW_SCALE     = 10;
	localparam int          FLOW_LIMIT     = 32500;
	localparam int          TEMP_SCALE     = 200;
	localparam int          MILLI_PER_UNIT = 1000;
	localparam int          TEMP_DIVISOR   = MILLI_PER_UNIT / TEMP_SCALE;
	localparam int          WORD_MAX       = 32767;
	localparam int          WORD_MIN       = -32768;

	// ----------------------------------------
	// link engine states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_WRITE,
		ST_ACK_WRITE,
		ST_READ,
		ST_ACK_READ
	} fsr_link_state_t;

	// msb first, no reflection
	function automatic logic [7:0] crc8(input logic [15:0] data);
		logic [7:0] crc;
		crc = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			if (crc[7] ^ data[i]) begin
				crc = {crc[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				crc = {crc[6:0], 1'b0};
			end
		end
		return crc ^ CRC_XOROUT;
	endfunction

endpackage
`default_nettype wire

/* File: src/fsr_readout.sv */
// serial-bus identification readout with checksum and measurement word encoding
`default_nettype none

// Summary of operation
// [R1] host writes 0x367C then 0xE102, each in its own write transaction
// [R2] read after both commands returns six words, each with checksum: 18 bytes
// [R3] first two words carry the 24-bit product code plus revision
// [R4] low eight bits of the product value are the revision
// [R5] last four words carry the 64-bit per-sensor serial value
// [R6] msb byte first; product bits 31..24 lead the reply
// [R7] checksum is crc-8, polynomial 0x31, init 0xFF, unreflected, final xor 0x00
// [R8] each checksum covers only the two bytes before it, restarting each word
// [R9] flow word is signed 16-bit, limited to -32500..32500
// [R10] flow word is flow rate times 10 per microlitre per minute
// [R11] temperature word is signed 16-bit, temperature times 200 per degree
// [R12] host stops continuous measurement before identification commands
// [R13] host nack then stop ends a read; sensor releases data line
// [R14] host reads identification only right after both commands
module fsr_readout #(
	parameter logic [6:0]  BUS_ADDR     = 7'h08,
	// arbitrary neutral value
	parameter logic [23:0] PRODUCT_CODE = 24'h00a5c3,
	parameter logic [7:0]  REVISION     = 8'h01
) (
	// system side
	input  wire logic               CLOCK,
	input  wire logic               RESET,
	// link side
	input  wire logic               SCL_CLK,
	input  wire logic               SDA_IN,
	output logic                    SDA_OUT,
	output logic                    SDA_OE,
	// per-sensor serial strap
	input  wire logic [63:0]        SERIAL_NUMBER,
	// calibrated measurements, same clock
	input  wire logic signed [23:0] FLOW_TENTH_UL,
	input  wire logic signed [23:0] TEMP_MILLI_C,
	// encoded measurement words
	output logic signed [15:0]      FLOW_WORD,
	output logic signed [15:0]      TEMP_WORD,
	// status
	output logic                    ID_ARMED
);

	// general call is shared by every device on the bus
	if (BUS_ADDR == 7'h00) begin
		$error("general call address cannot be the device address");
	end

	// ----------------------------------------
	// serial strap capture, system clock
	// ----------------------------------------
	logic [63:0] serial_meta;
	logic [63:0] serial_sync;
	logic [63:0] serial_hold;
	logic        serial_valid;
	logic [1:0]  settle;

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			serial_meta <= 64'h0;
			serial_sync <= 64'h0;
		end else begin
			serial_meta <= SERIAL_NUMBER;
			serial_sync <= serial_meta;
		end
	end

	// caught once after release, then held still for the link side
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			settle       <= 2'h0;
			serial_hold  <= 64'h0;
			serial_valid <= 1'b0;
		end else if (!serial_valid) begin
			settle <= settle + 2'h1;
			if (settle == fsr_pkg::SETTLE_LAST) begin
				serial_hold  <= serial_sync;
				serial_valid <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// measurement encoding
	// ----------------------------------------
	logic signed [23:0] temp_scaled;

	always_comb begin
		// [R11] scale by 200 per degree
		temp_scaled = TEMP_MILLI_C / 24'(fsr_pkg::TEMP_DIVISOR);
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			FLOW_WORD <= 16'h0;
		end else if (FLOW_TENTH_UL > 24'(fsr_pkg::FLOW_LIMIT)) begin
			// [R9] output limit clamp
			FLOW_WORD <= 16'(fsr_pkg::FLOW_LIMIT);
		end else if (FLOW_TENTH_UL < -24'(fsr_pkg::FLOW_LIMIT)) begin
			FLOW_WORD <= -16'(fsr_pkg::FLOW_LIMIT);
		end else begin
			// [R10] input already in tenths of a microlitre per minute
			FLOW_WORD <= FLOW_TENTH_UL[15:0];
		end
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			TEMP_WORD <= 16'h0;
		end else if (temp_scaled > 24'(fsr_pkg::WORD_MAX)) begin
			TEMP_WORD <= 16'(fsr_pkg::WORD_MAX);
		end else if (temp_scaled < 24'(fsr_pkg::WORD_MIN)) begin
			TEMP_WORD <= 16'(fsr_pkg::WORD_MIN);
		end else begin
			// [R11] two's complement word
			TEMP_WORD <= temp_scaled[15:0];
		end
	end

	// ----------------------------------------
	// valid level into the link domain
	// ----------------------------------------
	// serial_hold is static once valid rises, so the bus needs only the qualifier
	logic valid_meta;
	logic valid_link;

	always_ff @(posedge SCL_CLK or posedge RESET) begin
		if (RESET) begin
			valid_meta <= 1'b0;
			valid_link <= 1'b0;
		end else begin
			valid_meta <= serial_valid;
			valid_link <= valid_meta;
		end
	end

	// ----------------------------------------
	// reply content
	// ----------------------------------------
	logic [fsr_pkg::ID_BITS-1:0] id_data;
	logic [15:0]                 word;
	logic [7:0]                  tx_byte;
	logic [2:0]                  word_idx;
	logic [1:0]                  pos;

	always_comb begin
		// [R3] [R4] product code then revision in the low byte
		// [R5] serial after the product value
		id_data = {PRODUCT_CODE, REVISION, serial_hold};
		// [R6] product bits 31..24 go out first
		word = id_data[fsr_pkg::ID_BITS - 1 - 16 * word_idx -: 16];
		case (pos)
			fsr_pkg::POS_MSB: tx_byte = word[15:8];
			fsr_pkg::POS_LSB: tx_byte = word[7:0];
			// [R7] [R8] checksum of this word only
			default:          tx_byte = fsr_pkg::crc8(word);
		endcase
	end

	// ----------------------------------------
	// link engine, rising edge samples
	// ----------------------------------------
	fsr_pkg::fsr_link_state_t state;
	logic [2:0]  bit_cnt;
	logic [7:0]  shreg;
	logic        first_byte;
	logic [7:0]  cmd_hi;
	logic        id_stage;
	logic [4:0]  byte_cnt;
	logic        sda_rise;
	logic        start_seen;
	logic [7:0]  next_shreg;

	assign next_shreg = {shreg[6:0], SDA_IN};

	always_ff @(posedge SCL_CLK or posedge RESET) begin
		if (RESET) begin
			sda_rise <= 1'b1;
		end else begin
			sda_rise <= SDA_IN;
		end
	end

	always_ff @(posedge SCL_CLK or posedge RESET) begin
		if (RESET) begin
			state      <= fsr_pkg::ST_IDLE;
			bit_cnt    <= 3'h0;
			shreg      <= 8'h0;
			first_byte <= 1'b0;
			cmd_hi     <= 8'h0;
			id_stage   <= 1'b0;
			ID_ARMED   <= 1'b0;
			byte_cnt   <= 5'h0;
			word_idx   <= 3'h0;
			pos        <= 2'h0;
		end else if (start_seen) begin
			state   <= fsr_pkg::ST_ADDR;
			bit_cnt <= 3'h1;
			shreg   <= {7'h0, SDA_IN};
		end else begin
			case (state)
				fsr_pkg::ST_ADDR: begin
					shreg   <= next_shreg;
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == fsr_pkg::LAST_BIT) begin
						// reads are refused unless the id reply is armed
						if (next_shreg[7:1] == BUS_ADDR &&
								(!next_shreg[0] || (ID_ARMED && valid_link))) begin
							state <= fsr_pkg::ST_ACK_ADDR;
						end else begin
							state <= fsr_pkg::ST_IDLE;
						end
					end
				end
				fsr_pkg::ST_ACK_ADDR: begin
					bit_cnt    <= 3'h0;
					first_byte <= 1'b1;
					byte_cnt   <= 5'h0;
					word_idx   <= 3'h0;
					pos        <= fsr_pkg::POS_MSB;
					if (shreg[0]) begin
						// [R2] reply starts at the first byte
						state <= fsr_pkg::ST_READ;
					end else begin
						state <= fsr_pkg::ST_WRITE;
					end
				end
				fsr_pkg::ST_WRITE: begin
					shreg   <= next_shreg;
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == fsr_pkg::LAST_BIT) begin
						state      <= fsr_pkg::ST_ACK_WRITE;
						first_byte <= 1'b0;
						byte_cnt   <= byte_cnt + 5'h1;
						if (first_byte) begin
							cmd_hi <= next_shreg;
						end
						// [R1] two commands in order, each its own transaction
						if (byte_cnt == 5'h1) begin
							id_stage <= ({cmd_hi, next_shreg} == fsr_pkg::CMD_ID_FIRST);
							ID_ARMED <= id_stage &&
								({cmd_hi, next_shreg} == fsr_pkg::CMD_ID_SECOND);
						end else if (byte_cnt != 5'h0) begin
							id_stage <= 1'b0;
							ID_ARMED <= 1'b0;
						end
					end
				end
				fsr_pkg::ST_ACK_WRITE: begin
					bit_cnt <= 3'h0;
					state   <= fsr_pkg::ST_WRITE;
				end
				fsr_pkg::ST_READ: begin
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == fsr_pkg::LAST_BIT) begin
						state    <= fsr_pkg::ST_ACK_READ;
						byte_cnt <= byte_cnt + 5'h1;
						// [R8] crc restarts for every word
						if (pos == fsr_pkg::POS_CRC) begin
							pos      <= fsr_pkg::POS_MSB;
							word_idx <= word_idx + 3'h1;
						end else begin
							pos <= pos + 2'h1;
						end
					end
				end
				fsr_pkg::ST_ACK_READ: begin
					bit_cnt <= 3'h0;
					// [R13] nack ends the reply; [R2] so does the last byte
					if (SDA_IN || byte_cnt == fsr_pkg::REPLY_BYTES) begin
						state <= fsr_pkg::ST_IDLE;
					end else begin
						state <= fsr_pkg::ST_READ;
					end
				end
				default: begin
					state <= fsr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// link engine, falling edge drives
	// ----------------------------------------
	// start shows as data falling while the clock is high; a stop needs no edge
	// because the data line is already released during the host's nack slot
	logic start_now;

	assign start_now = sda_rise && !SDA_IN;

	always_ff @(negedge SCL_CLK or posedge RESET) begin
		if (RESET) begin
			start_seen <= 1'b0;
			SDA_OE     <= 1'b0;
		end else begin
			start_seen <= start_now;
			if (start_now) begin
				// [R13] never hold the line across a new frame
				SDA_OE <= 1'b0;
			end else begin
				case (state)
					fsr_pkg::ST_ACK_ADDR,
					fsr_pkg::ST_ACK_WRITE: SDA_OE <= 1'b1;
					// [R6] msb first, open drain pulls only for zeros
					fsr_pkg::ST_READ:      SDA_OE <= !tx_byte[fsr_pkg::LAST_BIT - bit_cnt];
					default:               SDA_OE <= 1'b0;
				endcase
			end
		end
	end

	assign SDA_OUT = 1'b0;

endmodule
`default_nettype wire
